// [rtl/serial_link_regs.sv]
// Purpose: Register slice of a serial converter output link behind an AXI4-Lite slave
// Assumes: One write and one read at most under way
// Notes:   Link status inputs may be asynchronous and are synchronised here; frameEndSlot goes to the mapper unsynchronised
// Function
// - Send identifier in second alignment multiframe
// - First link sends identifier, second sends plus one
// - Identifier bit 0 ignored, reads zero
// - Comma select: K28.7, K28.1, K28.5, reserved
// - Comma selection only in 8b/10b modes
// - Status bit 6 shows link up
// - Status bit 5 mirrors SYNC~ line
// - Status bit 4 sticky on SYSREF realignment
// - Write one clears bit 4 or 3
// - Bit 3 set by first SYSREF after enable
// - Status bit 2 shows PLL locked
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_params.svh"
module serial_link_regs
	import serial_link_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// AXI4-Lite write address
	input  wire logic [13:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// AXI4-Lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read address
	input  wire logic [13:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// AXI4-Lite read data
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Live link status
	input  wire logic        linkUp,
	input  wire logic        syncRequestN,
	input  wire logic        sysrefRealign,
	input  wire logic        sysrefEvent,
	input  wire logic        pllLocked,
	input  wire logic        frameEndSlot,
	// Link configuration out
	output logic      [7:0]  linkAIdentifier,
	output logic      [7:0]  linkBIdentifier,
	output logic             serialLinkEnable,
	output logic             linkMode64b66b,
	output logic      [7:0]  frameEndComma,
	output logic             frameEndInsert,
	// Interrupt
	output logic             irq
);

	// Address decode shared by both channels
	function automatic reg_sel_t decode(input logic [13:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		if (addr == `ADDR_LINK_ID)
			sel = SEL_LINK_ID;
		else if (addr == `ADDR_EOF_SEL)
			sel = SEL_EOF;
		else if (addr == `ADDR_LINK_STATUS)
			sel = SEL_STATUS;
		else if (addr == `ADDR_LINK_CTRL)
			sel = SEL_CTRL;
		else if (addr == `ADDR_INT_STATUS)
			sel = SEL_INT_STATUS;
		else if (addr == `ADDR_INT_MASK)
			sel = SEL_INT_MASK;
		return sel;
	endfunction

	// Live inputs after synchronisation
	wire logic [`IN_WIDTH-1:0] rawIn;      // Gathered inputs
	wire logic [`IN_WIDTH-1:0] syncIn;     // Settled inputs
	logic      [`IN_WIDTH-1:0] syncPrev_ff; // For edge detection

	assign rawIn = {pllLocked, sysrefEvent, sysrefRealign, syncRequestN, linkUp};

	// Every status source crosses here before any read sees it
	bit_sync #(
		.WIDTH   (`IN_WIDTH)
	) inSync (
		.clock   (clock),
		.reset   (reset),
		.asyncIn (rawIn),
		.syncOut (syncIn)
	);

	// Register storage
	logic [7:0] linkId_ff;       // Stored identifier, bit 0 always zero
	eof_sel_t   eofSel_ff;       // Comma selection
	logic [1:0] ctrl_ff;         // Enable and encoding mode
	logic       realigned_ff;    // Sticky realignment flag
	logic       multiframe_phase_set_flag_ff;      // Sticky phase-established flag
	logic       armed_ff;        // Waiting for first SYSREF after enable
	logic [2:0] intStatus_ff;    // Sticky interrupt events
	logic [2:0] intMask_ff;      // Interrupt enables
	logic [7:0] linkBId_ff;      // Second link identifier

	// Write channel holding registers
	wr_state_t   wrState_ff;     // Write progress
	logic        awHeld_ff;      // Address captured
	logic        wHeld_ff;       // Data captured
	logic [13:0] awAddr_ff;      // Captured address
	logic [31:0] wData_ff;       // Captured data
	logic        wLane0_ff;      // Low byte strobe
	logic        awready_ff;     // Outputs from flops
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        irq_ff;

	// Handshakes
	wire logic awTake;   // Address accepted this edge
	wire logic wTake;    // Data accepted this edge
	wire logic arTake;   // Read address accepted
	wire logic commit;   // Write performed this edge

	assign awTake = awvalid & awready_ff;
	assign wTake  = wvalid & wready_ff;
	assign arTake = arvalid & arready_ff;
	assign commit = (wrState_ff == WR_COMMIT);

	// Write decode
	wire reg_sel_t   wSel;       // Target of the pending write
	wire logic [7:0] wByte;      // Low data byte
	wire logic       wrId;       // Identifier write
	wire logic       wrEof;      // Comma select write
	wire logic       wrStatus;   // Status clear write
	wire logic       wrCtrl;     // Control write
	wire logic       wrIntSt;    // Interrupt clear write
	wire logic       wrIntMask;  // Mask write

	assign wSel      = decode(awAddr_ff);
	assign wByte     = wData_ff[7:0];
	assign wrId      = commit & wLane0_ff & (wSel == SEL_LINK_ID);
	assign wrEof     = commit & wLane0_ff & (wSel == SEL_EOF);
	assign wrStatus  = commit & wLane0_ff & (wSel == SEL_STATUS);
	assign wrCtrl    = commit & wLane0_ff & (wSel == SEL_CTRL);
	assign wrIntSt   = commit & wLane0_ff & (wSel == SEL_INT_STATUS);
	assign wrIntMask = commit & wLane0_ff & (wSel == SEL_INT_MASK);

	// Events seen on synchronised inputs, and the enable write
	wire logic realignEvt;   // SYSREF moved a clock phase
	wire logic sysrefEvt;    // Any SYSREF
	wire logic alignEvt;     // First SYSREF after enable
	wire logic pllLostEvt;   // Lock dropped
	wire logic enableRise;   // Link just enabled

	assign realignEvt = syncIn[`IN_REALIGN] & ~syncPrev_ff[`IN_REALIGN];
	assign sysrefEvt  = syncIn[`IN_SYSREF] & ~syncPrev_ff[`IN_SYSREF];
	assign alignEvt   = sysrefEvt & armed_ff & ctrl_ff[`CTRL_ENABLE];
	assign pllLostEvt = ~syncIn[`IN_PLL] & syncPrev_ff[`IN_PLL];
	assign enableRise = wrCtrl & wByte[`CTRL_ENABLE] & ~ctrl_ff[`CTRL_ENABLE];

	// Next values of the sticky state; a set wins over a clear
	wire logic       nxt_realigned;
	wire logic       nxt_multiframe_phase_set_flag;
	wire logic       nxt_armed;
	wire logic [2:0] nxt_intStatus;
	wire logic [2:0] intEvents;

	assign nxt_realigned = realignEvt |
		(realigned_ff & ~(wrStatus & wByte[`ST_REALIGNED]));
	assign nxt_multiframe_phase_set_flag   = alignEvt |
		(multiframe_phase_set_flag_ff & ~(wrStatus & wByte[`ST_MULTIFRAME_PHASE_SET_FLAG]));
	// Armed again on each enable; a disable drops it
	assign nxt_armed     = enableRise | (armed_ff & ~alignEvt & ctrl_ff[`CTRL_ENABLE]);
	assign intEvents     = {pllLostEvt, alignEvt, realignEvt};
	assign nxt_intStatus = intEvents | (intStatus_ff & ~({3{wrIntSt}} & wByte[2:0]));

	// Status word as read; reserved bits read zero
	wire logic [7:0] statusWord;
	assign statusWord = {1'b0,
		syncIn[`IN_LINK_UP],
		syncIn[`IN_SYNC_N],
		realigned_ff,
		multiframe_phase_set_flag_ff,
		syncIn[`IN_PLL],
		2'b00};

	// Read decode and data
	wire reg_sel_t    rSel;
	wire logic [7:0]  rByte;
	wire logic        rHit;
	assign rSel  = decode(araddr);
	assign rHit  = (rSel != SEL_NONE);
	assign rByte = (rSel == SEL_LINK_ID)    ? linkId_ff :
	               (rSel == SEL_EOF)        ? {6'h00, eofSel_ff} :
	               (rSel == SEL_STATUS)     ? statusWord :
	               (rSel == SEL_CTRL)       ? {6'h00, ctrl_ff} :
	               (rSel == SEL_INT_STATUS) ? {5'h00, intStatus_ff} :
	               (rSel == SEL_INT_MASK)   ? {5'h00, intMask_ff} : 8'h00;

	// Write state: collect both halves, commit, respond
	wire wr_state_t nxt_wrState;
	wire logic      nxt_awHeld;
	wire logic      nxt_wHeld;
	wire logic      nxt_bvalid;
	assign nxt_wrState = (wrState_ff == WR_COLLECT) ?
	                         ((nxt_awHeld & nxt_wHeld) ? WR_COMMIT : WR_COLLECT) :
	                     (wrState_ff == WR_COMMIT) ? WR_RESPOND :
	                     ((bready & bvalid_ff) ? WR_COLLECT : WR_RESPOND);
	assign nxt_awHeld  = (awHeld_ff | awTake) & ~(bready & bvalid_ff);
	assign nxt_wHeld   = (wHeld_ff | wTake) & ~(bready & bvalid_ff);
	assign nxt_bvalid  = commit | (bvalid_ff & ~bready);

	// Write channel flops
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wrState_ff <= WR_COLLECT;
			awHeld_ff  <= 1'b0;
			wHeld_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `RESP_OKAY;
		end else begin
			wrState_ff <= nxt_wrState;
			awHeld_ff  <= nxt_awHeld;
			wHeld_ff   <= nxt_wHeld;
			awready_ff <= ~nxt_awHeld;
			wready_ff  <= ~nxt_wHeld;
			bvalid_ff  <= nxt_bvalid;
			// Unmapped address answers with a slave error
			if (commit)
				bresp_ff <= (wSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
	end

	// Captured payloads; no reset needed for data path, kept for cleanliness
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			awAddr_ff <= '0;
			wData_ff  <= '0;
			wLane0_ff <= 1'b0;
		end else begin
			if (awTake)
				awAddr_ff <= awaddr;
			if (wTake) begin
				wData_ff  <= wdata;
				wLane0_ff <= wstrb[0];
			end
		end
	end

	// Read channel: answer in the cycle after the address is taken
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= `RESP_OKAY;
		end else begin
			arready_ff <= ~(arTake | (rvalid_ff & ~rready));
			if (arTake) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= {24'h00_0000, rByte};
				rresp_ff  <= rHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Configuration registers; software keeps the link disabled while changing them
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			linkId_ff  <= `RST_LINK_ID;
			eofSel_ff  <= EOF_K28_7;
			ctrl_ff    <= `RST_LINK_CTRL;
			intMask_ff <= `RST_INT;
		end else begin
			if (wrId)
				linkId_ff <= {wByte[7:1], 1'b0};
			if (wrEof)
				eofSel_ff <= eof_sel_t'(wByte[1:0]);
			if (wrCtrl)
				ctrl_ff <= wByte[1:0];
			if (wrIntMask)
				intMask_ff <= wByte[2:0];
		end
	end

	// Sticky flags, edge history, interrupt line
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			realigned_ff <= 1'b0;
			multiframe_phase_set_flag_ff   <= 1'b0;
			armed_ff     <= 1'b0;
			intStatus_ff <= `RST_INT;
			syncPrev_ff  <= '0;
			irq_ff       <= 1'b0;
		end else begin
			realigned_ff <= nxt_realigned;
			multiframe_phase_set_flag_ff   <= nxt_multiframe_phase_set_flag;
			armed_ff     <= nxt_armed;
			intStatus_ff <= nxt_intStatus;
			syncPrev_ff  <= syncIn;
			irq_ff       <= |(nxt_intStatus & intMask_ff);
		end
	end

	// Second link sends the identifier plus one, one cycle after the first, wrapping at 8 bits
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			linkBId_ff <= `RST_LINK_ID + 8'h01;
		else
			linkBId_ff <= 8'(linkId_ff + 8'h01);
	end

	// End-of-frame character and insertion strobe
	frame_end_mapper eofMap (
		.clock        (clock),
		.reset        (reset),
		.commaSelect  (eofSel_ff),
		.linkEnable   (ctrl_ff[`CTRL_ENABLE]),
		.mode64b66b   (ctrl_ff[`CTRL_MODE64]),
		.frameEndSlot (frameEndSlot),
		.eofChar_ff   (frameEndComma),
		.eofInsert_ff (frameEndInsert)
	);

	// Port drives
	assign awready          = awready_ff;
	assign wready           = wready_ff;
	assign bvalid           = bvalid_ff;
	assign bresp            = bresp_ff;
	assign arready          = arready_ff;
	assign rvalid           = rvalid_ff;
	assign rdata            = rdata_ff;
	assign rresp            = rresp_ff;
	assign linkAIdentifier  = linkId_ff;
	assign linkBIdentifier  = linkBId_ff;
	assign serialLinkEnable = ctrl_ff[`CTRL_ENABLE];
	assign linkMode64b66b   = ctrl_ff[`CTRL_MODE64];
	assign irq              = irq_ff;
endmodule
`default_nettype wire

// [rtl/serial_link_params.svh]
// Purpose: Offsets, field positions, codes and reset values for the link register slice
// Assumes: Included by the register and end-of-frame design files and the bench; the synchroniser and package do not include it
// Notes:   Definitions only; byte address is four times the register index
`ifndef SERIAL_LINK_PARAMS_SVH
`define SERIAL_LINK_PARAMS_SVH

// Register indices as printed, and the slice's own extra registers
`define IDX_LINK_ID        12'h0206
`define IDX_EOF_SEL        12'h0207
`define IDX_LINK_STATUS    12'h0208
`define IDX_LINK_CTRL      12'h0210
`define IDX_INT_STATUS     12'h0211
`define IDX_INT_MASK       12'h0212

// Byte addresses on the bus
`define ADDR_LINK_ID       14'h0818
`define ADDR_EOF_SEL       14'h081C
`define ADDR_LINK_STATUS   14'h0820
`define ADDR_LINK_CTRL     14'h0840
`define ADDR_INT_STATUS    14'h0844
`define ADDR_INT_MASK      14'h0848

// Reset values
`define RST_LINK_ID        8'h00
`define RST_EOF_SEL        2'h0
`define RST_LINK_CTRL      2'h0
`define RST_INT            3'h0

// Link status bit positions
`define ST_LINK_UP         6
`define ST_SYNC            5
`define ST_REALIGNED       4
`define ST_MULTIFRAME_PHASE_SET_FLAG         3
`define ST_PLL_LOCKED      2

// Control bit positions
`define CTRL_ENABLE        0
`define CTRL_MODE64        1

// Interrupt bit positions
`define INT_REALIGN        0
`define INT_MULTIFRAME_PHASE_SET_FLAG        1
`define INT_PLL_LOST       2

// Synchronised input positions
`define IN_LINK_UP         0
`define IN_SYNC_N          1
`define IN_REALIGN         2
`define IN_SYSREF          3
`define IN_PLL             4
`define IN_WIDTH           5

// Comma characters (K28.7, K28.1, K28.5)
`define K28_7              8'hFC
`define K28_1              8'h3C
`define K28_5              8'hBC

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [rtl/serial_link_pkg.sv]
// Purpose: Shared types of the link register slice
// Assumes: Constants live in serial_link_params.svh
// Notes:   Types only
package serial_link_pkg;

	// End-of-frame comma selection
	typedef enum logic [1:0] {
		EOF_K28_7    = 2'h0,
		EOF_K28_1    = 2'h1,
		EOF_K28_5    = 2'h2,
		EOF_RESERVED = 2'h3
	} eof_sel_t;

	// Write channel states, Gray from COLLECT to RESPOND; the return to COLLECT flips both bits
	typedef enum logic [1:0] {
		WR_COLLECT = 2'b00,
		WR_COMMIT  = 2'b01,
		WR_RESPOND = 2'b11
	} wr_state_t;

	// Register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_LINK_ID,
		SEL_EOF,
		SEL_STATUS,
		SEL_CTRL,
		SEL_INT_STATUS,
		SEL_INT_MASK
	} reg_sel_t;

endpackage

// [rtl/bit_sync.sv]
// Purpose: Two flip-flop synchroniser for a group of independent levels
// Assumes: Each bit is unrelated to the others; no bus coherence across bits
// Notes:   First stage feeds the second stage only
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// Levels in and out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_ff;   // Metastability catcher
	logic [WIDTH-1:0] stage2_ff;   // Settled copy

	// Two stages, constant reset
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;

endmodule
`default_nettype wire

// [rtl/frame_end_mapper.sv]
// Purpose: Turns the comma selection into the end-of-frame character and its insertion strobe
// Assumes: frameEndSlot is high in cycles where substitution is allowed by the framer
// Notes:   Outputs are registered; one cycle behind the slot
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_params.svh"
module frame_end_mapper
	import serial_link_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Configuration
	input  wire eof_sel_t   commaSelect,
	input  wire logic       linkEnable,
	input  wire logic       mode64b66b,
	// Framer side
	input  wire logic       frameEndSlot,
	output logic      [7:0] eofChar_ff,
	output logic            eofInsert_ff
);

	// Character for a selection; reserved falls back to the compliant one
	function automatic logic [7:0] commaOf(input eof_sel_t sel);
		logic [7:0] code;
		code = `K28_7;
		case (sel)
			EOF_K28_1: code = `K28_1;
			EOF_K28_5: code = `K28_5;
			default:   code = `K28_7;
		endcase
		return code;
	endfunction

	wire logic [7:0] nxt_eofChar;    // Mapped character
	wire logic       nxt_eofInsert;  // Substitution allowed now

	assign nxt_eofChar   = commaOf(commaSelect);
	// Only 8b/10b modes, only when the framer offers a slot
	assign nxt_eofInsert = linkEnable & ~mode64b66b & frameEndSlot;

	// Register the outputs
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			eofChar_ff   <= `K28_7;
			eofInsert_ff <= 1'b0;
		end else begin
			eofChar_ff   <= nxt_eofChar;
			eofInsert_ff <= nxt_eofInsert;
		end
	end

endmodule
`default_nettype wire

// [sim/serial_link_regs_monitor.sv]
// Purpose: Port checks of the link register slice
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Bound to the design from the bench top file
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_params.svh"
module serial_link_regs_monitor (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// Bus handshakes
	input wire logic        awready,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [13:0] araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// Link side
	input wire logic        frameEndSlot,
	input wire logic [7:0]  linkAIdentifier,
	input wire logic [7:0]  linkBIdentifier,
	input wire logic        serialLinkEnable,
	input wire logic        linkMode64b66b,
	input wire logic [7:0]  frameEndComma,
	input wire logic        frameEndInsert
);
	// Read address names a register
	wire logic mapped = araddr inside {`ADDR_LINK_ID, `ADDR_EOF_SEL, `ADDR_LINK_STATUS,
		`ADDR_LINK_CTRL, `ADDR_INT_STATUS, `ADDR_INT_MASK};
	// Read request taken this edge
	wire logic takeRd = arvalid && arready;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Answers stand until taken
	a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write channel open during response");
	// Read answered on the next edge, unmapped refused
	a_read_answer: assert property (
		takeRd |=> rvalid && rresp == (mapped ? `RESP_OKAY : `RESP_SLVERR))
		else $error("read answer late or wrong code");
	a_id_readback: assert property (
		takeRd && araddr == `ADDR_LINK_ID |=> rdata == {24'h0, linkAIdentifier} && !rdata[0])
		else $error("identifier readback wrong");
	// Second link follows the first one cycle later
	a_link_b_next: assert property (linkBIdentifier == $past(linkAIdentifier) + 8'h01)
		else $error("second link identifier not first plus one");
	a_comma_code: assert property (frameEndComma inside {`K28_7, `K28_1, `K28_5})
		else $error("comma character outside the three codes");
	// Insertion only in allowed slots of an 8b/10b link
	a_insert_cause: assert property (
		frameEndInsert == $past(serialLinkEnable && !linkMode64b66b && frameEndSlot))
		else $error("comma insertion without its cause");
endmodule
`default_nettype wire

// [sim/link_side_model.sv]
// Purpose: Far side of the slice: link status sources and framer slot
// Assumes: Levels change just after a rising edge, like the real link logic
// Notes:   The bench scripts events through the two tasks
`timescale 1ns/10ps
`default_nettype none
module link_side_model (
	// Clock
	input  wire logic clock,
	// Status levels towards the slice
	output logic      linkUp,
	output logic      syncRequestN,
	output logic      sysrefRealign,
	output logic      sysrefEvent,
	output logic      pllLocked,
	// Framer substitution slot
	output logic      frameEndSlot
);
	logic [1:0] slotCount_ff; // Frame position
	// Quiet link at start, SYNC~ asserted; channels stay powered so status is valid
	initial begin
		{linkUp, syncRequestN, sysrefRealign, sysrefEvent, pllLocked} = 5'h0;
		frameEndSlot = 1'b0;
		slotCount_ff = 2'h0;
	end
	// Substitution allowed on one frame end in four only
	always @(posedge clock) begin
		slotCount_ff <= slotCount_ff + 2'h1;
		frameEndSlot <= (slotCount_ff == 2'h3);
	end
	// Live levels
	task automatic set_levels(input logic up, input logic syncN, input logic lock);
		@(posedge clock);
		linkUp       <= up;
		syncRequestN <= syncN;
		pllLocked    <= lock;
	endtask
	// SYSREF shift or plain event, held so a slow edge is still seen
	task automatic pulse(input logic plain);
		@(posedge clock);
		if (plain)
			sysrefEvent <= 1'b1;
		else
			sysrefRealign <= 1'b1;
		repeat (3) @(posedge clock);
		sysrefEvent   <= 1'b0;
		sysrefRealign <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [sim/serial_link_param_status_regs_test.sv]
// Purpose: Self-checking bench of the link register slice
// Assumes: Link events come from link_side_model
// Notes:   Expectations come from a small model of the register contents
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_params.svh"
module serial_link_param_status_regs_test import serial_link_pkg::*;;
	// Clock, reset and bus drive
	logic        clock   = 1'b0;
	logic        reset   = 1'b1;
	logic [13:0] awaddr  = 14'h0;
	logic [13:0] araddr  = 14'h0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	// Design answers and link side
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic        linkUp, syncRequestN, sysrefRealign, sysrefEvent, pllLocked, frameEndSlot;
	logic [7:0]  linkAIdentifier, linkBIdentifier, frameEndComma, v;
	logic        serialLinkEnable, linkMode64b66b, frameEndInsert;
	// Counters and model state
	int          bad_count = 0;
	int          checks    = 0;
	int          mId;
	logic [3:0]  strb      = 4'hf; // Write strobes of the next write
	integer      seed      = 32'h2e22;
	logic [7:0]  commaTab [$] = '{`K28_7, `K28_1, `K28_5, `K28_7};
	always #10 clock = ~clock; // 50 MHz
	serial_link_regs DUT (
		.clock, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .linkUp, .syncRequestN, .sysrefRealign, .sysrefEvent, .pllLocked,
		.frameEndSlot, .linkAIdentifier, .linkBIdentifier, .serialLinkEnable,
		.linkMode64b66b, .frameEndComma, .frameEndInsert, .irq
	);
	link_side_model partner (
		.clock, .linkUp, .syncRequestN, .sysrefRealign, .sysrefEvent, .pllLocked, .frameEndSlot
	);
	// Word and pin comparisons
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
		check_word({24'h0, got}, {24'h0, exp});
	endtask
	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One write; address and data offered together, waits for the answer
	task automatic wr(input logic [13:0] a, input logic [31:0] val);
		@(posedge clock);
		awaddr  <= a;
		wdata   <= val;
		wstrb   <= strb;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clock);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	// One read, data and code taken at the answer edge
	task automatic rd(input logic [13:0] a);
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clock);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [13:0] a, input logic [31:0] e);
		rd(a);
		check_word(d, e);
		check_word(r, `RESP_OKAY);
	endtask
	// Synchroniser lag plus register stage, then off the edge
	task automatic settle;
		repeat (4) @(posedge clock);
		#1;
	endtask
	// Insertions over 40 cycles; slots come one in four
	task automatic count_inserts(input int e);
		int c;
		c = 0;
		repeat (40) begin
			@(posedge clock);
			c += (frameEndInsert === 1'b1);
		end
		check_word(c, e);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		rdchk(`ADDR_LINK_ID, 32'h0);
		rdchk(`ADDR_EOF_SEL, 32'h0);
		rdchk(`ADDR_LINK_STATUS, 32'h0);
		// Settings changed while the link is still off
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hff : 8'($random(seed) | 1);
			mId = v & 8'hfe;
			wr(`ADDR_LINK_ID, {24'h0, v});
			check_word(r, `RESP_OKAY);
			rdchk(`ADDR_LINK_ID, mId);
			settle;
			check_pin(linkAIdentifier, mId);
			check_pin(linkBIdentifier, 8'(mId + 1));
		end
		// A write without the low byte lane leaves the identifier alone
		strb = 4'he;
		wr(`ADDR_LINK_ID, 32'h0);
		strb = 4'hf;
		rdchk(`ADDR_LINK_ID, mId);
		for (int s = 0; s < 4; s++) begin
			wr(`ADDR_EOF_SEL, s);
			rdchk(`ADDR_EOF_SEL, s);
			settle;
			check_pin(frameEndComma, commaTab[s]);
		end
		wr(`ADDR_EOF_SEL, 0);
		// Live levels, every combination
		for (int k = 0; k < 8; k++) begin
			partner.set_levels(k[2], k[1], k[0]);
			settle;
			rdchk(`ADDR_LINK_STATUS, {1'b0, k[2], k[1], 2'b00, k[0], 2'b00});
		end
		// Lock losses are pending but masked
		check_pin(irq, 0);
		wr(`ADDR_INT_MASK, 4);
		settle;
		check_pin(irq, 1);
		wr(`ADDR_INT_STATUS, 4);
		settle;
		check_pin(irq, 0);
		wr(`ADDR_INT_MASK, 7);
		partner.pulse(1'b0);
		settle;
		rdchk(`ADDR_LINK_STATUS, 32'h74);
		check_pin(irq, 1);
		wr(`ADDR_LINK_STATUS, 32'h08);
		rdchk(`ADDR_LINK_STATUS, 32'h74);
		wr(`ADDR_LINK_STATUS, 32'h10);
		rdchk(`ADDR_LINK_STATUS, 32'h64);
		wr(`ADDR_INT_STATUS, 7);
		settle;
		check_pin(irq, 0);
		// Event before enable is ignored, first after enable sets, second does not
		partner.pulse(1'b1);
		settle;
		rdchk(`ADDR_LINK_STATUS, 32'h64);
		wr(`ADDR_LINK_CTRL, 1);
		partner.pulse(1'b1);
		settle;
		rdchk(`ADDR_LINK_STATUS, 32'h6c);
		wr(`ADDR_LINK_STATUS, 32'h08);
		partner.pulse(1'b1);
		settle;
		rdchk(`ADDR_LINK_STATUS, 32'h64);
		count_inserts(10);
		wr(`ADDR_LINK_CTRL, 3);
		settle;
		check_pin({6'h00, linkMode64b66b, serialLinkEnable}, 8'h03);
		count_inserts(0);
		wr(`ADDR_LINK_CTRL, 0);
		// Unmapped place refused both ways
		wr(14'h0004, 32'h5a);
		check_word(r, `RESP_SLVERR);
		rd(14'h0004);
		check_word(r, `RESP_SLVERR);
		close_out;
	end
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		close_out;
	end
endmodule
bind serial_link_regs serial_link_regs_monitor mon (
	.clock, .reset, .awready, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
	.arready, .rdata, .rresp, .rvalid, .rready, .frameEndSlot, .linkAIdentifier,
	.linkBIdentifier, .serialLinkEnable, .linkMode64b66b, .frameEndComma, .frameEndInsert
);
`default_nettype wire
